// File: include/link_mon_pkg.sv
package link_mon_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int LED_HALF_MS = 250;

  // Register indices
  localparam logic [15:0] ADDR_GROUP_UPPER = 16'h0030;
  localparam logic [15:0] ADDR_GROUP_LOWER = 16'h0031;
  localparam logic [15:0] ADDR_TMO_UPPER = 16'h1200;
  localparam logic [15:0] ADDR_TMO_LOWER = 16'h1201;
  localparam logic [15:0] ADDR_ERRCNT_UPPER = 16'h1202;
  localparam logic [15:0] ADDR_ERRCNT_LOWER = 16'h1203;

  // Ranges and reset values
  localparam logic [31:0] GROUP_NONE = 32'hffffffff;
  localparam logic [31:0] GROUP_MIN = 32'h00000001;
  localparam logic [31:0] GROUP_MAX = 32'h0000001f;
  localparam logic [31:0] TMO_MAX = 32'h00002710;
  localparam logic [31:0] TMO_RESET = 32'h00000000;
  localparam logic [31:0] ERRCNT_MIN = 32'h00000001;
  localparam logic [31:0] ERRCNT_MAX = 32'h0000000a;
  localparam logic [31:0] ERRCNT_RESET = 32'h00000003;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [3:0] RATE_SW_BAD = 4'h8;

  // Error codes
  localparam logic [7:0] ERR_SWITCH = 8'h83;
  localparam logic [7:0] ERR_TRANSMIT = 8'h84;
  localparam logic [7:0] ERR_TIMEOUT = 8'h85;
  localparam logic [7:0] ERR_UNDEFINED = 8'h88;
  localparam logic [7:0] ERR_PANEL_BUSY = 8'h89;
  localparam logic [7:0] ERR_NV_BUSY = 8'h8a;
  localparam logic [7:0] ERR_RANGE = 8'h8c;
  localparam logic [7:0] ERR_STATE = 8'h8d;

  // Exception codes
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] EXC_EXEC = 8'h04;

  // Slot function codes
  localparam logic [7:0] F_NONE = 8'h00;
  localparam logic [7:0] F_CW = 8'h01;
  localparam logic [7:0] F_CCW = 8'h02;
  localparam logic [7:0] F_STOP_METHOD = 8'h13;
  localparam logic [7:0] F_BRAKE_REL = 8'h14;
  localparam logic [7:0] F_PANEL_REL = 8'h1b;
  localparam logic [7:0] F_REMOTE0 = 8'h20;
  localparam logic [7:0] F_REMOTE15 = 8'h2f;
  localparam logic [7:0] F_DSEL0 = 8'h30;
  localparam logic [7:0] F_DSEL3 = 8'h33;
  localparam logic [7:0] F_TLIM_SEL = 8'h36;
  localparam logic [7:0] F_FAULT_OK = 8'h41;
  localparam logic [7:0] F_WARNING = 8'h42;
  localparam logic [7:0] F_MOTION = 8'h44;
  localparam logic [7:0] F_TLIM_FLAG = 8'h47;
  localparam logic [7:0] F_SPEED_AT = 8'h4d;
  localparam logic [7:0] F_BUSY = 8'h50;
  localparam logic [7:0] F_FAULT_2ND = 8'h51;
  localparam logic [7:0] F_MAIN_PWR = 8'h52;
  localparam logic [7:0] F_TURN_SENSE = 8'h54;

  typedef enum logic [1:0] {CAUSE_VALUE, CAUSE_PANEL, CAUSE_NV, CAUSE_STATE} exc_cause_t;

  typedef struct packed {
    logic done;
    logic err;
    logic [7:0] addr;
  } frame_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic ack;
    logic exc;
    logic [15:0] rdata;
  } reg_rsp_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    exc_cause_t cause;
  } exc_in_t;

  typedef struct packed {
    logic motion;
    logic tlim;
    logic speed_at;
    logic busy;
    logic main_pwr;
    logic turn_sense;
  } drive_stat_t;

  typedef struct packed {
    logic cw;
    logic ccw;
    logic stop_method;
    logic brake_rel;
    logic panel_rel;
    logic tlim_sel;
    logic [15:0] remote;
    logic [3:0] dsel;
  } in_func_t;

endpackage : link_mon_pkg

// File: hw/link_mon.sv
`timescale 1ns/1ns
module link_mon
  import link_mon_pkg::*;
#(
  parameter int N_SLOT = 16,
  parameter int REC_DEPTH = 16,
  parameter int MS_CYCLES = CYC_PER_MS,
  parameter int LED_HALF_CYCLES = LED_HALF_MS * CYC_PER_MS
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // Station setup and switch pin
  input wire logic [7:0] STATION_ADDR,
  input wire logic [3:0] RATE_SW,
  // Frame events from the receiver
  input wire frame_t FRAME,
  input wire exc_in_t EXC,
  // Register access from the query decoder
  input wire reg_req_t REG_REQ,
  output reg_rsp_t REG_RSP,
  // Error record read command
  input wire logic ERR_REC_RD,
  input wire logic [7:0] ERR_REC_IDX,
  output logic [7:0] ERR_REC_DATA,
  output logic [7:0] ERR_REC_COUNT,
  // Query handling
  output logic EXECUTE,
  output logic RESPOND,
  // Alarm and warning
  output logic FAULT_OK_OUT,
  output logic FAULT_LED,
  output logic MOTOR_STOP,
  output logic WARNING_OUT,
  output logic [7:0] ALARM_CODE,
  // Link slots
  input wire logic [N_SLOT-1:0][7:0] LINK_IN_SEL,
  input wire logic [N_SLOT-1:0] LINK_IN_BITS,
  input wire logic [N_SLOT-1:0][7:0] LINK_OUT_SEL,
  input wire drive_stat_t DRIVE_STAT,
  output in_func_t IN_FUNC,
  output logic [N_SLOT-1:0] LINK_OUT_BITS
);

  localparam int PW = $clog2(REC_DEPTH);

  typedef struct packed {
    logic [3:0] sw_meta;
    logic [3:0] sw_sync;
    logic [31:0] group;
    logic [15:0] group_hold;
    logic [31:0] tmo;
    logic [15:0] tmo_hold;
    logic [31:0] errcnt;
    logic [15:0] errcnt_hold;
    logic [REC_DEPTH-1:0][7:0] rec;
    logic [PW-1:0] rec_wp;
    logic [7:0] rec_cnt;
    logic [7:0] rec_data;
    logic [31:0] consec;
    logic [31:0] ms_sub;
    logic [31:0] ms_cnt;
    logic [31:0] led_cnt;
    logic warn;
    logic alarm;
    logic fault_ok;
    logic sw_logged;
    logic led;
    logic [7:0] alarm_code;
    logic execute;
    logic respond;
    reg_rsp_t rsp;
    in_func_t in_func;
    logic [N_SLOT-1:0] out_bits;
  } st_t;

  st_t s_r;
  st_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  function automatic logic [7:0] exc_log_code(input exc_in_t e);
    exc_log_code = ERR_UNDEFINED;
    if (e.code == EXC_VALUE) begin
      exc_log_code = ERR_RANGE;
    end else if (e.code == EXC_EXEC) begin
      unique case (e.cause)
        CAUSE_PANEL: exc_log_code = ERR_PANEL_BUSY;
        CAUSE_NV: exc_log_code = ERR_NV_BUSY;
        CAUSE_VALUE: exc_log_code = ERR_RANGE;
        CAUSE_STATE: exc_log_code = ERR_STATE;
      endcase
    end
  endfunction : exc_log_code

  function automatic in_func_t decode_in(input in_func_t acc, input logic [7:0] code,
                                         input logic b);
    in_func_t f;
    f = acc;
    if (code == F_CW) f.cw = f.cw | b;
    if (code == F_CCW) f.ccw = f.ccw | b;
    if (code == F_STOP_METHOD) f.stop_method = f.stop_method | b;
    if (code == F_BRAKE_REL) f.brake_rel = f.brake_rel | b;
    if (code == F_PANEL_REL) f.panel_rel = f.panel_rel | b;
    if (code == F_TLIM_SEL) f.tlim_sel = f.tlim_sel | b;
    if (code >= F_REMOTE0 && code <= F_REMOTE15) begin
      f.remote[code[3:0]] = f.remote[code[3:0]] | b;
    end
    if (code >= F_DSEL0 && code <= F_DSEL3) begin
      f.dsel[code[1:0]] = f.dsel[code[1:0]] | b;
    end
    decode_in = f;
  endfunction : decode_in

  function automatic logic out_value(input logic [7:0] code, input in_func_t f,
                                     input drive_stat_t d, input logic alarm,
                                     input logic warn);
    out_value = 1'b0;
    if (code == F_CW) out_value = f.cw;
    if (code == F_CCW) out_value = f.ccw;
    if (code == F_STOP_METHOD) out_value = f.stop_method;
    if (code == F_BRAKE_REL) out_value = f.brake_rel;
    if (code == F_PANEL_REL) out_value = f.panel_rel;
    if (code == F_TLIM_SEL) out_value = f.tlim_sel;
    if (code >= F_REMOTE0 && code <= F_REMOTE15) out_value = f.remote[code[3:0]];
    if (code >= F_DSEL0 && code <= F_DSEL3) out_value = f.dsel[code[1:0]];
    if (code == F_FAULT_OK) out_value = ~alarm;
    if (code == F_WARNING) out_value = warn;
    if (code == F_MOTION) out_value = d.motion;
    if (code == F_TLIM_FLAG) out_value = d.tlim;
    if (code == F_SPEED_AT) out_value = d.speed_at;
    if (code == F_BUSY) out_value = d.busy;
    if (code == F_FAULT_2ND) out_value = ~alarm;
    if (code == F_MAIN_PWR) out_value = d.main_pwr;
    if (code == F_TURN_SENSE) out_value = d.turn_sense;
  endfunction : out_value

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic good;
    logic [7:0] log_code;
    logic log_en;
    logic [31:0] wval;
    logic [PW-1:0] rd_ptr;
    in_func_t f;
    good = FRAME.done & ~FRAME.err;
    log_code = 8'h00;
    log_en = 1'b0;
    wval = 32'h00000000;
    rd_ptr = '0;
    f = '0;
    s_nxt = s_r;
    s_nxt.execute = 1'b0;
    s_nxt.respond = 1'b0;
    s_nxt.rsp = '0;

    // Two-stage synchroniser on the switch pin
    s_nxt.sw_meta = RATE_SW;
    s_nxt.sw_sync = s_r.sw_meta;

    // Addressing: child follows parent address, only own address answers
    if (good) begin
      if (FRAME.addr == STATION_ADDR) begin
        s_nxt.execute = 1'b1;
        s_nxt.respond = 1'b1;
      end else if (FRAME.addr == BCAST_ADDR) begin
        s_nxt.execute = 1'b1;
      end else if (in_range(s_r.group, GROUP_MIN, GROUP_MAX) &&
                   FRAME.addr == s_r.group[7:0]) begin
        s_nxt.execute = 1'b1;
      end
    end

    // Transmission errors, warning and error alarm
    if (FRAME.done && FRAME.err) begin
      log_en = 1'b1;
      log_code = ERR_TRANSMIT;
      s_nxt.warn = 1'b1;
      s_nxt.consec = s_r.consec + 32'h00000001;
      if (s_r.consec + 32'h00000001 >= s_r.errcnt && !s_r.alarm) begin
        s_nxt.alarm = 1'b1;
        s_nxt.alarm_code = ERR_TRANSMIT;
      end
    end else if (good) begin
      s_nxt.warn = 1'b0;
      s_nxt.consec = 32'h00000000;
    end

    // Register access; the master pairs the halves, upper first
    if (REG_REQ.wr || REG_REQ.rd) begin
      s_nxt.rsp.ack = 1'b1;
      unique case (REG_REQ.addr)
        ADDR_GROUP_UPPER: s_nxt.rsp.rdata = s_r.group[31:16];
        ADDR_GROUP_LOWER: s_nxt.rsp.rdata = s_r.group[15:0];
        ADDR_TMO_UPPER: s_nxt.rsp.rdata = s_r.tmo[31:16];
        ADDR_TMO_LOWER: s_nxt.rsp.rdata = s_r.tmo[15:0];
        ADDR_ERRCNT_UPPER: s_nxt.rsp.rdata = s_r.errcnt[31:16];
        ADDR_ERRCNT_LOWER: s_nxt.rsp.rdata = s_r.errcnt[15:0];
        default: s_nxt.rsp.exc = 1'b1;
      endcase
      if (REG_REQ.wr) begin
        s_nxt.rsp.rdata = 16'h0000;
        unique case (REG_REQ.addr)
          ADDR_GROUP_UPPER: s_nxt.group_hold = REG_REQ.wdata;
          ADDR_TMO_UPPER: s_nxt.tmo_hold = REG_REQ.wdata;
          ADDR_ERRCNT_UPPER: s_nxt.errcnt_hold = REG_REQ.wdata;
          ADDR_GROUP_LOWER: begin
            wval = {s_r.group_hold, REG_REQ.wdata};
            if (wval == GROUP_NONE || in_range(wval, GROUP_MIN, GROUP_MAX)) begin
              s_nxt.group = wval;
            end else begin
              s_nxt.rsp.exc = 1'b1;
            end
          end
          ADDR_TMO_LOWER: begin
            wval = {s_r.tmo_hold, REG_REQ.wdata};
            if (wval <= TMO_MAX) begin
              s_nxt.tmo = wval;
            end else begin
              s_nxt.rsp.exc = 1'b1;
            end
          end
          ADDR_ERRCNT_LOWER: begin
            wval = {s_r.errcnt_hold, REG_REQ.wdata};
            if (in_range(wval, ERRCNT_MIN, ERRCNT_MAX)) begin
              s_nxt.errcnt = wval;
            end else begin
              s_nxt.rsp.exc = 1'b1;
            end
          end
          default: s_nxt.rsp.exc = 1'b1;
        endcase
      end
    end
    // Exceptions from the query decoder; one log entry per cycle
    if (!log_en && EXC.valid) begin
      log_en = 1'b1;
      log_code = exc_log_code(EXC);
    end

    // Rate switch error, logged once and latched as an alarm
    if (s_r.sw_sync >= RATE_SW_BAD && !s_r.alarm) begin
      s_nxt.alarm = 1'b1;
      s_nxt.alarm_code = ERR_SWITCH;
    end
    if (!log_en && s_r.sw_sync >= RATE_SW_BAD && !s_r.sw_logged) begin
      log_en = 1'b1;
      log_code = ERR_SWITCH;
      s_nxt.sw_logged = 1'b1;
    end

    // Timeout supervision, restarted by each good frame
    if (good || s_r.tmo == TMO_RESET) begin
      s_nxt.ms_sub = 32'h00000000;
      s_nxt.ms_cnt = 32'h00000000;
    end else if (!s_r.alarm) begin
      if (s_r.ms_sub == 32'(MS_CYCLES - 1)) begin
        s_nxt.ms_sub = 32'h00000000;
        s_nxt.ms_cnt = s_r.ms_cnt + 32'h00000001;
        if (s_r.ms_cnt + 32'h00000001 >= s_r.tmo) begin
          s_nxt.alarm = 1'b1;
          s_nxt.alarm_code = ERR_TIMEOUT;
        end
      end else begin
        s_nxt.ms_sub = s_r.ms_sub + 32'h00000001;
      end
    end

    // Error record: ring buffer, newest at index 0, oldest overwritten
    if (log_en) begin
      s_nxt.rec[s_r.rec_wp] = log_code;
      s_nxt.rec_wp = s_r.rec_wp + PW'(1);
      if (s_r.rec_cnt < 8'(REC_DEPTH)) begin
        s_nxt.rec_cnt = s_r.rec_cnt + 8'h01;
      end
    end
    if (ERR_REC_RD) begin
      rd_ptr = s_r.rec_wp - PW'(1) - ERR_REC_IDX[PW-1:0];
      s_nxt.rec_data = (ERR_REC_IDX < s_r.rec_cnt) ? s_r.rec[rd_ptr] : 8'h00;
    end

    // Fault LED blinks only while an alarm stands
    if (s_r.alarm) begin
      if (s_r.led_cnt == 32'(LED_HALF_CYCLES - 1)) begin
        s_nxt.led_cnt = 32'h00000000;
        s_nxt.led = ~s_r.led;
      end else begin
        s_nxt.led_cnt = s_r.led_cnt + 32'h00000001;
      end
    end
    if (!s_r.alarm && s_nxt.alarm) begin
      s_nxt.led = 1'b1;
    end
    s_nxt.fault_ok = ~s_nxt.alarm;

    // Link slots
    for (int i = 0; i < N_SLOT; i++) begin
      f = decode_in(f, LINK_IN_SEL[i], LINK_IN_BITS[i]);
    end
    s_nxt.in_func = f;
    for (int i = 0; i < N_SLOT; i++) begin
      s_nxt.out_bits[i] = out_value(LINK_OUT_SEL[i], f, DRIVE_STAT, s_nxt.alarm,
                                    s_nxt.warn);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; reset is power-up, so nothing survives it

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_r <= '0;
      s_r.group <= GROUP_NONE;
      s_r.tmo <= TMO_RESET;
      s_r.errcnt <= ERRCNT_RESET;
      s_r.fault_ok <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign REG_RSP = s_r.rsp;
  assign ERR_REC_DATA = s_r.rec_data;
  assign ERR_REC_COUNT = s_r.rec_cnt;
  assign EXECUTE = s_r.execute;
  assign RESPOND = s_r.respond;
  assign FAULT_OK_OUT = s_r.fault_ok;
  assign MOTOR_STOP = s_r.alarm;
  assign FAULT_LED = s_r.led;
  assign WARNING_OUT = s_r.warn;
  assign ALARM_CODE = s_r.alarm_code;
  assign IN_FUNC = s_r.in_func;
  assign LINK_OUT_BITS = s_r.out_bits;

endmodule : link_mon

// File: verification/link_mon_props.sv
`timescale 1ns/1ns
module link_mon_props
  import link_mon_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // Watched inputs
  input wire logic [7:0] STATION_ADDR,
  input wire logic [3:0] RATE_SW,
  input wire frame_t FRAME,
  input wire reg_req_t REG_REQ,
  // Watched outputs
  input wire reg_rsp_t REG_RSP,
  input wire logic EXECUTE,
  input wire logic RESPOND,
  input wire logic FAULT_OK_OUT,
  input wire logic FAULT_LED,
  input wire logic MOTOR_STOP,
  input wire logic WARNING_OUT,
  input wire logic [7:0] ALARM_CODE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  ////////////////////////////////////////
  own_reply_a: assert property (
    FRAME.done && !FRAME.err && FRAME.addr == STATION_ADDR |=> EXECUTE && RESPOND)
    else $error("own frame not answered");
  reply_own_only_a: assert property (
    RESPOND |-> $past(FRAME.done) && !$past(FRAME.err) && $past(FRAME.addr) == STATION_ADDR)
    else $error("reply without own frame");
  bad_frame_quiet_a: assert property (
    FRAME.done && FRAME.err |=> !EXECUTE && !RESPOND)
    else $error("faulty frame executed");
  warn_raise_a: assert property (
    FRAME.done && FRAME.err |=> WARNING_OUT)
    else $error("no warning after error");
  warn_clear_a: assert property (
    FRAME.done && !FRAME.err && FRAME.addr == STATION_ADDR |=> !WARNING_OUT)
    else $error("warning kept after good frame");
  alarm_onset_a: assert property (
    $fell(FAULT_OK_OUT) |-> MOTOR_STOP && FAULT_LED)
    else $error("alarm outputs out of step");
  stop_pair_a: assert property (
    FAULT_OK_OUT != MOTOR_STOP)
    else $error("stop and ok disagree");
  alarm_hold_a: assert property (
    !FAULT_OK_OUT |=> !FAULT_OK_OUT && $stable(ALARM_CODE))
    else $error("alarm dropped");
  reg_answer_a: assert property (
    REG_RSP.ack == ($past(REG_REQ.wr) || $past(REG_REQ.rd)))
    else $error("register answer timing");
  // Six samples cover the two sync stages plus the alarm register
  switch_alarm_a: assert property (
    RATE_SW[3] [*6] |-> !FAULT_OK_OUT)
    else $error("bad rate switch not flagged");
endmodule : link_mon_props

bind link_mon link_mon_props i_link_mon_props (.MCLK, .ARST_N, .STATION_ADDR, .RATE_SW,
  .FRAME, .REG_REQ, .REG_RSP, .EXECUTE, .RESPOND, .FAULT_OK_OUT, .FAULT_LED, .MOTOR_STOP,
  .WARNING_OUT, .ALARM_CODE);

// File: verification/query_master.sv
`timescale 1ns/1ns
module query_master
  import link_mon_pkg::*;
(
  // Clock
  input wire logic MCLK,
  // Query side
  output frame_t frame,
  output exc_in_t exc,
  output reg_req_t req,
  input wire reg_rsp_t rsp
);
  initial begin
    frame = '0;
    exc = '0;
    req = '0;
  end
  ////////////////////////////////////////
  // Released lines carry the inverse so stale values never look valid
  task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output reg_rsp_t r);
    @(posedge MCLK) #1;
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge MCLK) #1;
    r = rsp;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : access
  task automatic put32(input logic [15:0] a, input logic [31:0] v, output logic e);
    reg_rsp_t r;
    access(1'b1, a, v[31:16], r);
    e = r.exc;
    access(1'b1, a + 16'h0001, v[15:0], r);
    e = e | r.exc;
  endtask : put32
  task automatic get32(input logic [15:0] a, output logic [31:0] v);
    reg_rsp_t r;
    access(1'b0, a, 16'h0000, r);
    v[31:16] = r.rdata;
    access(1'b0, a + 16'h0001, 16'h0000, r);
    v[15:0] = r.rdata;
  endtask : get32
  task automatic send(input logic [7:0] a, input logic e);
    @(posedge MCLK) #1;
    frame = '{done: 1'b1, err: e, addr: a};
    @(posedge MCLK) #1;
    frame = '{done: 1'b0, err: 1'b0, addr: ~a};
  endtask : send
  task automatic fault(input logic [7:0] c, input exc_cause_t k);
    @(posedge MCLK) #1;
    exc = '{valid: 1'b1, code: c, cause: k};
    @(posedge MCLK) #1;
    exc = '{valid: 1'b0, code: ~c, cause: k};
  endtask : fault
endmodule : query_master

// File: verification/link_mon_tb.sv
`timescale 1ns/1ns
module link_mon_tb
  import link_mon_pkg::*;
;
  logic MCLK = 1'b0;
  logic ARST_N = 1'b0;
  logic [7:0] STATION_ADDR = 8'h05;
  logic [3:0] RATE_SW = 4'h0;
  frame_t FRAME;
  exc_in_t EXC;
  reg_req_t REG_REQ;
  reg_rsp_t REG_RSP;
  logic ERR_REC_RD = 1'b0;
  logic [7:0] ERR_REC_IDX = 8'h00;
  logic [7:0] ERR_REC_DATA;
  logic [7:0] ERR_REC_COUNT;
  logic EXECUTE, RESPOND, FAULT_OK_OUT, FAULT_LED, MOTOR_STOP, WARNING_OUT;
  logic [7:0] ALARM_CODE;
  logic [15:0][7:0] LINK_IN_SEL = '0;
  logic [15:0] LINK_IN_BITS = 16'hffff;
  logic [15:0][7:0] LINK_OUT_SEL = '0;
  drive_stat_t DRIVE_STAT = '1;
  in_func_t IN_FUNC;
  logic [15:0] LINK_OUT_BITS;
  int miscompares = 0;
  int n_compared = 0;
  logic [31:0] v;
  logic e;
  logic [47:0] bad [6] = '{{ADDR_GROUP_UPPER, 32'h00000000},
    {ADDR_GROUP_UPPER, GROUP_MAX + 32'h1}, {ADDR_TMO_UPPER, TMO_MAX + 32'h1},
    {ADDR_ERRCNT_UPPER, 32'h00000000}, {ADDR_ERRCNT_UPPER, ERRCNT_MAX + 32'h1},
    {16'h0040, 32'h00000000}};
  logic [9:0] fr [4] = '{{8'h07, 2'b10}, {8'h05, 2'b11}, {8'h09, 2'b00}, {BCAST_ADDR, 2'b10}};
  logic [17:0] ex [7] = '{{EXC_FUNC, CAUSE_VALUE, ERR_UNDEFINED},
    {EXC_ADDR, CAUSE_VALUE, ERR_UNDEFINED}, {EXC_VALUE, CAUSE_VALUE, ERR_RANGE},
    {EXC_EXEC, CAUSE_PANEL, ERR_PANEL_BUSY}, {EXC_EXEC, CAUSE_NV, ERR_NV_BUSY},
    {EXC_EXEC, CAUSE_VALUE, ERR_RANGE}, {EXC_EXEC, CAUSE_STATE, ERR_STATE}};
  logic [8:0] sl [20] = '{{1'b0, F_NONE}, {1'b1, F_CW}, {1'b1, F_CCW},
    {1'b1, F_STOP_METHOD}, {1'b1, F_BRAKE_REL}, {1'b1, F_PANEL_REL}, {1'b1, F_REMOTE0},
    {1'b1, F_REMOTE15}, {1'b1, F_DSEL0}, {1'b1, F_DSEL3}, {1'b1, F_TLIM_SEL},
    {1'b1, F_FAULT_OK}, {1'b0, F_WARNING}, {1'b1, F_MOTION}, {1'b1, F_TLIM_FLAG},
    {1'b1, F_SPEED_AT}, {1'b1, F_BUSY}, {1'b1, F_FAULT_2ND}, {1'b1, F_MAIN_PWR},
    {1'b1, F_TURN_SENSE}};
  ////////////////////////////////////////
  link_mon #(.MS_CYCLES(10), .LED_HALF_CYCLES(4)) i_link_mon (.MCLK, .ARST_N,
    .STATION_ADDR, .RATE_SW, .FRAME, .EXC, .REG_REQ, .REG_RSP, .ERR_REC_RD, .ERR_REC_IDX,
    .ERR_REC_DATA, .ERR_REC_COUNT, .EXECUTE, .RESPOND, .FAULT_OK_OUT, .FAULT_LED,
    .MOTOR_STOP, .WARNING_OUT, .ALARM_CODE, .LINK_IN_SEL, .LINK_IN_BITS, .LINK_OUT_SEL,
    .DRIVE_STAT, .IN_FUNC, .LINK_OUT_BITS);
  query_master i_query_master (.MCLK, .frame(FRAME), .exc(EXC), .req(REG_REQ),
    .rsp(REG_RSP));
  initial begin
    forever #5 MCLK = ~MCLK;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic pwr_cycle();
    ARST_N = 1'b0;
    repeat (8) @(posedge MCLK);
    #1;
    ARST_N = 1'b1;
  endtask : pwr_cycle
  task automatic rec(input logic [7:0] exp);
    @(posedge MCLK) #1;
    ERR_REC_RD = 1'b1;
    @(posedge MCLK) #1;
    ERR_REC_RD = 1'b0;
    chk(ERR_REC_DATA, exp);
  endtask : rec
  task automatic report_and_stop();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // Whole sequence needs well under 5000 cycles
  initial begin
    #500000;
    miscompares++;
    report_and_stop();
  end
  ////////////////////////////////////////
  initial begin
    pwr_cycle();
    i_query_master.get32(ADDR_GROUP_UPPER, v);
    chk(v, GROUP_NONE);
    i_query_master.get32(ADDR_TMO_UPPER, v);
    chk(v, TMO_RESET);
    i_query_master.get32(ADDR_ERRCNT_UPPER, v);
    chk(v, ERRCNT_RESET);
    foreach (bad[i]) begin
      i_query_master.put32(bad[i][47:32], bad[i][31:0], e);
      chk(e, 1'b1);
    end
    i_query_master.put32(ADDR_GROUP_UPPER, 32'h00000007, e);
    i_query_master.get32(ADDR_GROUP_UPPER, v);
    chk(e, 1'b0);
    chk(v, 32'h00000007);
    foreach (fr[i]) begin
      i_query_master.send(fr[i][9:2], 1'b0);
      chk({EXECUTE, RESPOND}, fr[i][1:0]);
    end
    foreach (ex[i]) begin
      i_query_master.fault(ex[i][17:10], exc_cause_t'(ex[i][9:8]));
      rec(ex[i][7:0]);
    end
    // Count of two shows whether a good frame really restarts the run
    i_query_master.put32(ADDR_ERRCNT_UPPER, 32'h00000002, e);
    i_query_master.send(8'h05, 1'b1);
    chk(WARNING_OUT, 1'b1);
    rec(ERR_TRANSMIT);
    i_query_master.send(8'h05, 1'b0);
    chk({WARNING_OUT, FAULT_OK_OUT}, 2'b01);
    i_query_master.send(8'h05, 1'b1);
    chk(FAULT_OK_OUT, 1'b1);
    i_query_master.send(8'h05, 1'b1);
    chk({FAULT_OK_OUT, MOTOR_STOP, FAULT_LED, ALARM_CODE}, {3'b011, ERR_TRANSMIT});
    // One half period later the LED has toggled while the stop holds
    repeat (4) @(posedge MCLK);
    #1;
    chk({FAULT_LED, MOTOR_STOP}, 2'b01);
    pwr_cycle();
    chk({ERR_REC_COUNT, WARNING_OUT}, 9'h000);
    i_query_master.get32(ADDR_GROUP_UPPER, v);
    chk(v, GROUP_NONE);
    i_query_master.put32(ADDR_TMO_UPPER, 32'h00000003, e);
    i_query_master.send(8'h05, 1'b0);
    repeat (25) @(posedge MCLK);
    #1;
    chk(FAULT_OK_OUT, 1'b1);
    repeat (10) @(posedge MCLK);
    #1;
    chk(ALARM_CODE, ERR_TIMEOUT);
    pwr_cycle();
    RATE_SW = 4'h7;
    repeat (8) @(posedge MCLK);
    #1;
    chk(FAULT_OK_OUT, 1'b1);
    RATE_SW = RATE_SW_BAD;
    repeat (8) @(posedge MCLK);
    #1;
    chk(ALARM_CODE, ERR_SWITCH);
    rec(ERR_SWITCH);
    RATE_SW = 4'h0;
    pwr_cycle();
    foreach (sl[i]) begin
      LINK_IN_SEL[0] = sl[i][7:0];
      LINK_OUT_SEL[0] = sl[i][7:0];
      repeat (2) @(posedge MCLK);
      #1;
      chk(LINK_OUT_BITS[0], sl[i][8]);
      chk(|IN_FUNC, sl[i][8] & (sl[i][7:0] < 8'h40));
    end
    report_and_stop();
  end
endmodule : link_mon_tb
